// ---- common/adc_dig_regs.vh ----
/*
 Constants for the converter digital back-end register bank: byte
 addresses, field positions, reset values and the gain lookup table.
 Assumes inclusion by its bare name from the rtl and tb files.
*/
// Operation
// - Freeze code 111 holds the last offset estimate
// - Bit 2 clear runs corrector; set bypasses it
// - Gain code in 1 dB steps, 0-11 dB
// - Separate gain register per channel via page
// - Reset bit pulsed 0-1-0 resets both channels
// - Zone settings take effect only on reset pulse
// - Zone enable clear means zone code ignored
// - Zone codes 000, 001, 010 select zones 1-3
// - Zone code 011 selects the fourth zone
`ifndef ADC_DIG_REGS_VH
`define ADC_DIG_REGS_VH

// -----------------------------------------------------------------------
// Register indices and byte addresses (byte address = index * 4)
// -----------------------------------------------------------------------
`define IDX_CORE_RESET   12'h000
`define IDX_OFFSET_CTRL  12'h068
`define IDX_ZONE_SELECT  12'h0A2
`define IDX_GAIN         12'h0A6
`define IDX_PAGE_SELECT  12'h0C0
`define IDX_STATUS       12'h0C4
`define ADDR_CORE_RESET  12'h000
`define ADDR_OFFSET_CTRL 12'h1A0
`define ADDR_ZONE_SELECT 12'h288
`define ADDR_GAIN        12'h298
`define ADDR_PAGE_SELECT 12'h300
`define ADDR_STATUS      12'h310

// -----------------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------------
`define BIT_CORE_RESET   0
`define BIT_FREEZE_HI    7
`define BIT_FREEZE_MID   5
`define BIT_BYPASS       2
`define BIT_FREEZE_LO    1
`define BIT_OFFS_SPARE   0
`define BIT_ZONE_EN      3
`define BIT_PAGE_CH_B    0

// -----------------------------------------------------------------------
// Reset values and codes
// -----------------------------------------------------------------------
`define RST_OFFSET_CTRL  8'h00
`define RST_ZONE_SELECT  8'h00
`define RST_GAIN         4'h0
`define FREEZE_CODE      3'h7
`define GAIN_CODE_MAX    4'hB
`define RESP_OKAY        2'h0
`define RESP_SLVERR      2'h2

// -----------------------------------------------------------------------
// Gain coefficients, unsigned Q4.12, 10^(dB/20)
// -----------------------------------------------------------------------
`define GAIN_FRAC_BITS   12
`define GAIN_DB0  16'h1000
`define GAIN_DB1  16'h11F4
`define GAIN_DB2  16'h1425
`define GAIN_DB3  16'h169A
`define GAIN_DB4  16'h195C
`define GAIN_DB5  16'h1C74
`define GAIN_DB6  16'h1FED
`define GAIN_DB7  16'h23D2
`define GAIN_DB8  16'h2831
`define GAIN_DB9  16'h2D18
`define GAIN_DB10 16'h3299
`define GAIN_DB11 16'h38C5

// Offset estimator averaging shift
`define EST_SHIFT 8

`endif

// ---- rtl/sample_gain.v ----
/*
 Per-channel digital gain stage ahead of the down-converter.
 Assumes samples and the gain code are synchronous to aclk.
*/
`timescale 1ns/1ps
`include "adc_dig_regs.vh"
module sample_gain (
   input  wire               aclk,
   input  wire               aresetn,
   input  wire               core_rst,
   input  wire [3:0]         gain_code,
   input  wire signed [13:0] din,
   input  wire               din_valid,
   output reg  signed [13:0] dout,
   output reg                dout_valid
);
   reg  [15:0]        coef;     // Linear coefficient for the code
   wire signed [30:0] prod;     // Full product
   wire signed [30:0] scaled;   // Product back to sample scale

   // --------------------------------------------------------------------
   // Code to coefficient; unused codes fall back to 0 dB
   // --------------------------------------------------------------------
   always @*
   begin
      case (gain_code)
         4'h0:    coef = `GAIN_DB0;
         4'h1:    coef = `GAIN_DB1;
         4'h2:    coef = `GAIN_DB2;
         4'h3:    coef = `GAIN_DB3;
         4'h4:    coef = `GAIN_DB4;
         4'h5:    coef = `GAIN_DB5;
         4'h6:    coef = `GAIN_DB6;
         4'h7:    coef = `GAIN_DB7;
         4'h8:    coef = `GAIN_DB8;
         4'h9:    coef = `GAIN_DB9;
         4'hA:    coef = `GAIN_DB10;
         4'hB:    coef = `GAIN_DB11;
         default: coef = `GAIN_DB0;
      endcase
   end

   assign prod   = din * $signed({1'b0, coef});
   assign scaled = prod >>> `GAIN_FRAC_BITS;

   // --------------------------------------------------------------------
   // Saturating output register
   // --------------------------------------------------------------------
   always @(posedge aclk)
   begin
      if (!aresetn || core_rst)
      begin
         dout       <= 14'h0000;
         dout_valid <= 1'b0;
      end
      else
      begin
         dout_valid <= din_valid;
         if (scaled > 31'sd8191)
            dout <= 14'h1FFF;
         else if (scaled < -31'sd8192)
            dout <= 14'h2000;
         else
            dout <= scaled[13:0];
      end
   end
endmodule

// ---- rtl/offset_corrector.v ----
/*
 Running-average offset corrector for one converter channel.
 Assumes control bits are stable register outputs on aclk.
*/
`timescale 1ns/1ps
`include "adc_dig_regs.vh"
module offset_corrector (
   input  wire               aclk,
   input  wire               aresetn,
   input  wire               core_rst,
   input  wire               freeze,
   input  wire               bypass,
   input  wire signed [13:0] din,
   input  wire               din_valid,
   output reg  signed [13:0] dout,
   output reg                dout_valid
);
   reg  signed [22:0] acc;       // Offset estimate scaled by 2^shift
   wire signed [22:0] est;       // Current offset estimate
   wire signed [14:0] diff;      // Sample minus estimate

   assign est  = acc >>> `EST_SHIFT;
   assign diff = {din[13], din} - est[14:0];

   // --------------------------------------------------------------------
   // Estimator and corrected output
   // --------------------------------------------------------------------
   always @(posedge aclk)
   begin
      if (!aresetn || core_rst)
      begin
         acc        <= 23'h00_0000;
         dout       <= 14'h0000;
         dout_valid <= 1'b0;
      end
      else
      begin
         dout_valid <= din_valid;
         // Frozen: estimate held, last value still applied
         if (din_valid && !freeze && !bypass)
            acc <= acc + {{8{diff[14]}}, diff};
         if (bypass)
            dout <= din;
         else if (diff > 15'sd8191)
            dout <= 14'h1FFF;
         else if (diff < -15'sd8192)
            dout <= 14'h2000;
         else
            dout <= diff[13:0];
      end
   end
endmodule

// ---- rtl/adc_digital_control_regs.v ----
/*
 Register bank and control for the converter digital back end:
 channel B offset corrector, per-channel gain, global core reset and
 zone selection for the analog correction loop.
 Assumes an AXI4-Lite master on aclk and samples synchronous to aclk.
*/
`timescale 1ns/1ps
`include "adc_dig_regs.vh"
module adc_digital_control_regs (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [11:0] s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output wire        s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output wire        s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [11:0] s_axi_araddr,
   input  wire        s_axi_arvalid,
   output wire        s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire [13:0] samp_in_a,
   input  wire [13:0] samp_in_b,
   input  wire        samp_in_valid,
   output wire [13:0] samp_out_a,
   output wire [13:0] samp_out_b,
   output wire        samp_out_valid,
   output reg         core_reset_pulse,
   output reg         zone_spec_active,
   output reg  [3:0]  zone_onehot,
   output wire        corrector_frozen
);
   // --------------------------------------------------------------------
   // Storage
   // --------------------------------------------------------------------
   reg        aw_held;          // Write address captured
   reg [11:0] aw_addr;          // Captured write address
   reg        w_held;           // Write data captured
   reg [31:0] w_data;           // Captured write data
   reg [3:0]  w_strb;           // Captured byte enables
   reg        global_core_reset_pulse; // Software reset bit
   reg        reset_bit_dly;    // Reset bit one cycle earlier
   reg        freeze_hi;        // Offset control bit 7
   reg        freeze_mid;       // Offset control bit 5
   reg        freeze_lo;        // Offset control bit 1
   reg        corrector_bypass; // Offset control bit 2
   reg        offs_spare;       // Offset control bit 0
   reg        zone_spec_enable; // Programmed zone enable
   reg [2:0]  zone_code;        // Programmed zone code
   reg [2:0]  applied_zone;     // Zone code latched at reset pulse
   reg        page_ch_b;        // Gain page: 0 channel A, 1 channel B
   reg [3:0]  gain_a;           // Channel A gain code
   reg [3:0]  gain_b;           // Channel B gain code
   reg [13:0] samp_a_dly;       // Channel A aligned to corrector
   reg        samp_valid_dly;   // Valid aligned to corrector
   reg [31:0] next_rdata;       // Read mux result
   reg        next_rmapped;     // Read address decodes

   wire        wr_fire;         // Write performed this cycle
   wire        wr_lane0;        // Low byte lane enabled
   wire [7:0]  wbyte;           // Low data byte
   wire        wr_mapped;       // Write address decodes
   wire [11:0] aw_word;         // Word-aligned write address
   wire [11:0] ar_word;         // Word-aligned read address
   wire [13:0] corr_b;          // Channel B after offset correction
   wire        corr_valid;      // Corrector output valid
   wire [27:0] gain_in;         // Both channels into gain stages
   wire [7:0]  gain_codes;      // Both gain codes
   wire [27:0] gain_out;        // Both channels out of gain stages
   wire [1:0]  gain_valid;      // Gain stage valid per channel

   // --------------------------------------------------------------------
   // Write channel handshakes
   // --------------------------------------------------------------------
   assign s_axi_awready = !aw_held && !s_axi_bvalid;
   assign s_axi_wready  = !w_held && !s_axi_bvalid;
   assign wr_fire       = aw_held && w_held && !s_axi_bvalid;
   assign aw_word       = {aw_addr[11:2], 2'b00};
   assign wr_lane0      = w_strb[0];
   assign wbyte         = w_data[7:0];
   assign wr_mapped     = (aw_word == `ADDR_CORE_RESET)  ||
                          (aw_word == `ADDR_OFFSET_CTRL) ||
                          (aw_word == `ADDR_ZONE_SELECT) ||
                          (aw_word == `ADDR_GAIN)        ||
                          (aw_word == `ADDR_PAGE_SELECT) ||
                          (aw_word == `ADDR_STATUS);

   // Address and data captured independently, in either order
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_held      <= 1'b0;
         aw_addr      <= 12'h000;
         w_held       <= 1'b0;
         w_data       <= 32'h0000_0000;
         w_strb       <= 4'h0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= `RESP_OKAY;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         // Response after both halves are in
         if (wr_fire)
         begin
            aw_held      <= 1'b0;
            w_held       <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
         end
         else if (s_axi_bvalid && s_axi_bready)
            s_axi_bvalid <= 1'b0;
      end
   end

   // --------------------------------------------------------------------
   // Register writes; reserved bits are dropped
   // --------------------------------------------------------------------
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         global_core_reset_pulse <= 1'b0;
         freeze_hi        <= 1'b0;
         freeze_mid       <= 1'b0;
         freeze_lo        <= 1'b0;
         corrector_bypass <= 1'b0;
         offs_spare       <= 1'b0;
         zone_spec_enable <= 1'b0;
         zone_code        <= 3'h0;
         page_ch_b        <= 1'b0;
         gain_a           <= `RST_GAIN;
         gain_b           <= `RST_GAIN;
      end
      else if (wr_fire && wr_lane0)
      begin
         case (aw_word)
            `ADDR_CORE_RESET:
               global_core_reset_pulse <= wbyte[`BIT_CORE_RESET];
            `ADDR_OFFSET_CTRL:
            begin
               // Bits 7, 5, 1 form the freeze field
               freeze_hi        <= wbyte[`BIT_FREEZE_HI];
               freeze_mid       <= wbyte[`BIT_FREEZE_MID];
               freeze_lo        <= wbyte[`BIT_FREEZE_LO];
               corrector_bypass <= wbyte[`BIT_BYPASS];
               offs_spare       <= wbyte[`BIT_OFFS_SPARE];
            end
            `ADDR_ZONE_SELECT:
            begin
               // Stored only; applied at the next reset pulse
               zone_spec_enable <= wbyte[`BIT_ZONE_EN];
               zone_code        <= wbyte[2:0];
            end
            `ADDR_GAIN:
            begin
               // Page selects which channel's gain is written
               if (page_ch_b)
                  gain_b <= wbyte[3:0];
               else
                  gain_a <= wbyte[3:0];
            end
            `ADDR_PAGE_SELECT:
               page_ch_b <= wbyte[`BIT_PAGE_CH_B];
            default:
               page_ch_b <= page_ch_b;
         endcase
      end
   end

   // --------------------------------------------------------------------
   // Global core reset: falling edge of the bit ends a 0-1-0 pulse
   // --------------------------------------------------------------------
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         reset_bit_dly    <= 1'b0;
         core_reset_pulse <= 1'b0;
      end
      else
      begin
         reset_bit_dly    <= global_core_reset_pulse;
         core_reset_pulse <= reset_bit_dly &&
                             !global_core_reset_pulse;
      end
   end

   // --------------------------------------------------------------------
   // Zone settings latched by the reset pulse and decoded
   // --------------------------------------------------------------------
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         zone_spec_active <= 1'b0;
         applied_zone     <= 3'h0;
         zone_onehot      <= 4'h0;
      end
      else if (core_reset_pulse)
      begin
         zone_spec_active <= zone_spec_enable;
         applied_zone     <= zone_code;
         // Enable clear: no zone is driven to the loop
         if (!zone_spec_enable)
            zone_onehot <= 4'h0;
         else
         begin
            case (zone_code)
               3'h0:    zone_onehot <= 4'h1;
               3'h1:    zone_onehot <= 4'h2;
               3'h2:    zone_onehot <= 4'h4;
               3'h3:    zone_onehot <= 4'h8;
               default: zone_onehot <= 4'h0;
            endcase
         end
      end
   end

   // --------------------------------------------------------------------
   // Read channel: one-cycle answer
   // --------------------------------------------------------------------
   assign s_axi_arready = !s_axi_rvalid;
   assign ar_word       = {s_axi_araddr[11:2], 2'b00};

   // Read mux; reserved bits read zero
   always @*
   begin
      next_rdata   = 32'h0000_0000;
      next_rmapped = 1'b1;
      case (ar_word)
         `ADDR_CORE_RESET:
            next_rdata[`BIT_CORE_RESET] = global_core_reset_pulse;
         `ADDR_OFFSET_CTRL:
         begin
            next_rdata[`BIT_FREEZE_HI]  = freeze_hi;
            next_rdata[`BIT_FREEZE_MID] = freeze_mid;
            next_rdata[`BIT_BYPASS]     = corrector_bypass;
            next_rdata[`BIT_FREEZE_LO]  = freeze_lo;
            next_rdata[`BIT_OFFS_SPARE] = offs_spare;
         end
         `ADDR_ZONE_SELECT:
         begin
            next_rdata[`BIT_ZONE_EN] = zone_spec_enable;
            next_rdata[2:0]          = zone_code;
         end
         `ADDR_GAIN:
            next_rdata[3:0] = page_ch_b ? gain_b : gain_a;
         `ADDR_PAGE_SELECT:
            next_rdata[`BIT_PAGE_CH_B] = page_ch_b;
         `ADDR_STATUS:
            next_rdata[4:0] = {corrector_frozen, zone_spec_active,
                               applied_zone};
         default:
            next_rmapped = 1'b0;
      endcase
   end

   // Read data register
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= `RESP_OKAY;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= next_rdata;
         s_axi_rresp  <= next_rmapped ? `RESP_OKAY : `RESP_SLVERR;
      end
      else if (s_axi_rvalid && s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // --------------------------------------------------------------------
   // Channel B offset corrector; freeze only on code 111
   // --------------------------------------------------------------------
   assign corrector_frozen = ({freeze_hi, freeze_mid, freeze_lo} ==
                              `FREEZE_CODE);

   offset_corrector u_offset_b (
      .aclk       (aclk),
      .aresetn    (aresetn),
      .core_rst   (core_reset_pulse),
      .freeze     (corrector_frozen),
      .bypass     (corrector_bypass),
      .din        (samp_in_b),
      .din_valid  (samp_in_valid),
      .dout       (corr_b),
      .dout_valid (corr_valid)
   );

   // Channel A delayed to match the corrector latency
   always @(posedge aclk)
   begin
      if (!aresetn || core_reset_pulse)
      begin
         samp_a_dly     <= 14'h0000;
         samp_valid_dly <= 1'b0;
      end
      else
      begin
         samp_a_dly     <= samp_in_a;
         samp_valid_dly <= samp_in_valid;
      end
   end

   // --------------------------------------------------------------------
   // Gain stages, one per channel
   // --------------------------------------------------------------------
   assign gain_in    = {corr_b, samp_a_dly};
   assign gain_codes = {gain_b, gain_a};

   genvar ch;
   generate
      for (ch = 0; ch < 2; ch = ch + 1)
      begin : g_gain
         sample_gain u_gain (
            .aclk       (aclk),
            .aresetn    (aresetn),
            .core_rst   (core_reset_pulse),
            .gain_code  (gain_codes[ch*4 +: 4]),
            .din        (gain_in[ch*14 +: 14]),
            .din_valid  (ch == 0 ? samp_valid_dly : corr_valid),
            .dout       (gain_out[ch*14 +: 14]),
            .dout_valid (gain_valid[ch])
         );
      end
   endgenerate

   assign samp_out_a     = gain_out[13:0];
   assign samp_out_b     = gain_out[27:14];
   assign samp_out_valid = gain_valid[0] && gain_valid[1];
endmodule

// ---- tb/adc_regs_props.sv ----
/*
 Checker for the register bank bus handshake and zone outputs.
 Assumes binding onto the top module ports.
*/
`timescale 1ns/1ps
module adc_regs_props (
   input wire        aclk,
   input wire        aresetn,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire        core_reset_pulse,
   input wire        zone_spec_active,
   input wire [3:0]  zone_onehot
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // ------------------------------------------------
   // Bus steps
   // ------------------------------------------------
   sequence both_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence resp_wait;
      s_axi_bvalid && !s_axi_bready;
   endsequence
   write_answer_a: assert property (both_taken |-> ##[1:2] s_axi_bvalid)
      else $error("write response missing");
   bresp_hold_a: assert property (resp_wait |=>
      s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   aw_block_a: assert property (s_axi_awvalid && s_axi_awready |=>
      !s_axi_awready) else $error("address taken twice");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid) else $error("read data missing");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   // ------------------------------------------------
   // Core reset and zone
   // ------------------------------------------------
   pulse_single_a: assert property (core_reset_pulse |=>
      !core_reset_pulse) else $error("reset pulse too long");
   zone_latch_a: assert property (!core_reset_pulse |=>
      $stable(zone_onehot)) else $error("zone moved off pulse");
   zone_off_a: assert property (!zone_spec_active |->
      zone_onehot == 4'h0) else $error("zone used while off");
   zone_onehot_a: assert property ($onehot0(zone_onehot))
      else $error("zone decode not one hot");
endmodule
bind adc_digital_control_regs adc_regs_props u_props (.*);

// ---- tb/adc_digital_control_regs_tb_top.sv ----
/*
 Register bank bench: AXI4-Lite tasks and directed sequences.
 Assumes the constants header is on the include path.
*/
`timescale 1ns/1ps
`include "adc_dig_regs.vh"
module adc_digital_control_regs_tb_top;
   reg aclk = 0, aresetn = 0;
   reg [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   reg [31:0] s_axi_wdata = 0;
   reg [3:0]  s_axi_wstrb = 4'hF;
   reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   reg s_axi_arvalid = 0, s_axi_rready = 0, samp_in_valid = 0;
   reg [13:0] samp_in_a = 0, samp_in_b = 0;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire s_axi_rvalid, samp_out_valid, core_reset_pulse;
   wire zone_spec_active, corrector_frozen;
   wire [1:0]  s_axi_bresp, s_axi_rresp;
   wire [31:0] s_axi_rdata;
   wire [13:0] samp_out_a, samp_out_b;
   wire [3:0]  zone_onehot;
   integer err_count = 0, n_checks = 0, i;
   reg [3:0] prev;
   adc_digital_control_regs uut (.*);
   always #2 aclk = ~aclk;
   // ------------------------------------------------
   // Compare and bus tasks
   // ------------------------------------------------
   task chk(input [31:0] got, input [31:0] exp);
   begin
      n_checks = n_checks + 1;
      if (got !== exp)
      begin
         err_count = err_count + 1;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   end
   endtask
   // Write one byte; each half is dropped at the rising edge taking it
   task wr(input [11:0] a, input [7:0] d, input [1:0] er);
      reg ad, wd;
   begin
      ad = 0; wd = 0;
      @(posedge aclk);
      s_axi_awaddr <= a; s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1; s_axi_wvalid <= 1;
      while (!(ad && wd))
      begin
         @(posedge aclk);
         if (!ad && s_axi_awready) begin s_axi_awvalid <= 0; ad = 1; end
         if (!wd && s_axi_wready) begin s_axi_wvalid <= 0; wd = 1; end
      end
      // Response seen waiting, then accepted at the next rising edge
      while (!s_axi_bvalid) @(posedge aclk);
      s_axi_bready <= 1;
      @(posedge aclk);
      s_axi_bready <= 0;
      chk({30'h0, s_axi_bresp}, {30'h0, er});
   end
   endtask
   // Read one byte; data taken at the edge of the rready handshake
   task rd(input [11:0] a, input [7:0] ed, input [1:0] er);
   begin
      @(posedge aclk); s_axi_araddr <= a; s_axi_arvalid <= 1;
      @(posedge aclk);
      while (!s_axi_arready) @(posedge aclk);
      s_axi_arvalid <= 0;
      while (!s_axi_rvalid) @(posedge aclk);
      s_axi_rready <= 1;
      @(posedge aclk);
      s_axi_rready <= 0;
      chk(s_axi_rdata, {24'h0, ed});
      chk({30'h0, s_axi_rresp}, {30'h0, er});
   end
   endtask
   // Core reset pulse 0-1-0, then let the zone outputs settle
   task pulse;
   begin
      wr(`ADDR_CORE_RESET, 8'h01, 2'h0);
      wr(`ADDR_CORE_RESET, 8'h00, 2'h0);
      repeat (4) @(posedge aclk);
      @(negedge aclk);
   end
   endtask
   task results;
   begin
      $display("checks %0d errors %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   end
   endtask
   initial
   begin
      repeat (20000) @(posedge aclk);
      err_count = err_count + 1;
      results;
   end
   // ------------------------------------------------
   // Tests
   // ------------------------------------------------
   initial
   begin
      repeat (12) @(posedge aclk);
      aresetn <= 1;
      rd(`ADDR_OFFSET_CTRL, 8'h00, 2'h0);
      rd(`ADDR_GAIN, 8'h00, 2'h0);
      wr(`ADDR_OFFSET_CTRL, 8'h22, 2'h0);
      chk(corrector_frozen, 0);
      wr(`ADDR_OFFSET_CTRL, 8'hFE, 2'h0);
      rd(`ADDR_OFFSET_CTRL, 8'hA6, 2'h0);
      chk(corrector_frozen, 1);
      wr(`ADDR_PAGE_SELECT, 8'h00, 2'h0);
      wr(`ADDR_GAIN, 8'hFB, 2'h0);
      wr(`ADDR_PAGE_SELECT, 8'h01, 2'h0);
      wr(`ADDR_GAIN, 8'h05, 2'h0);
      rd(`ADDR_GAIN, 8'h05, 2'h0);
      wr(`ADDR_PAGE_SELECT, 8'h00, 2'h0);
      rd(`ADDR_GAIN, 8'h0B, 2'h0);
      // Low byte lane off: the gain write must be ignored
      s_axi_wstrb <= 4'hE;
      wr(`ADDR_GAIN, 8'h03, 2'h0);
      s_axi_wstrb <= 4'hF;
      rd(`ADDR_GAIN, 8'h0B, 2'h0);
      // Samples: A at 11 dB, B bypassed at 5 dB
      samp_in_a <= 14'h0100; samp_in_b <= 14'h0100; samp_in_valid <= 1;
      repeat (4) @(posedge aclk);
      chk(samp_out_a, 14'h038C);
      chk(samp_out_b, 14'h01C7);
      chk(samp_out_valid, 1);
      wr(12'h004, 8'h55, 2'h2);
      rd(12'h004, 8'h00, 2'h2);
      prev = 4'h0;
      for (i = 0; i < 4; i = i + 1)
      begin
         wr(`ADDR_ZONE_SELECT, 8'h08, 2'h0);
         wr(`ADDR_ZONE_SELECT, 8'h08 | i, 2'h0);
         chk(zone_onehot, prev);
         pulse;
         prev = 4'h1 << i;
         chk(zone_onehot, prev);
         chk(zone_spec_active, 1);
      end
      wr(`ADDR_ZONE_SELECT, 8'hF2, 2'h0);
      rd(`ADDR_ZONE_SELECT, 8'h02, 2'h0);
      pulse;
      chk(zone_onehot, 0);
      chk(zone_spec_active, 0);
      rd(`ADDR_STATUS, 8'h12, 2'h0);
      results;
   end
endmodule
